// >>> verilog/tpc_pkg.sv
package tpc_pkg;
  // register indices on the plain port
  localparam logic [3:0] ADDR_EVEN_CTRL = 4'h0;
  localparam logic [3:0] ADDR_ODD_CTRL  = 4'h1;
  localparam logic [3:0] ADDR_EVEN_CNT  = 4'h2;
  localparam logic [3:0] ADDR_ODD_CNT   = 4'h3;
  localparam logic [3:0] ADDR_EVEN_PER  = 4'h4;
  localparam logic [3:0] ADDR_ODD_PER   = 4'h5;
  localparam logic [3:0] ADDR_CAP_CTRL  = 4'h6;
  localparam logic [3:0] ADDR_CAP_BUF   = 4'h7;
  localparam logic [3:0] ADDR_STATUS    = 4'h8;
  // timer control field positions
  localparam int TC_RUN   = 15;
  localparam int TC_IDLE  = 13;
  localparam int TC_GATE  = 6;
  localparam int TC_PSHI  = 5;
  localparam int TC_PSLO  = 4;
  localparam int TC_JOIN  = 3;
  localparam int TC_CSRC  = 1;
  // writable masks, unimplemented bits read zero
  localparam logic [15:0] EVEN_CTRL_MASK = 16'hA07A;
  localparam logic [15:0] ODD_CTRL_MASK  = 16'hA072;
  localparam logic [15:0] CAP_CTRL_MASK  = 16'h20E7;
  // capture control field positions
  localparam int CC_IDLE  = 13;
  localparam int CC_TMR   = 7;
  localparam int CC_CPHI  = 6;
  localparam int CC_CPLO  = 5;
  localparam int CC_OVF   = 4;
  localparam int CC_BNE   = 3;
  localparam int CC_MDHI  = 2;
  // prescale terminal counts
  localparam logic [7:0] PS_DIV1   = 8'h00;
  localparam logic [7:0] PS_DIV8   = 8'h07;
  localparam logic [7:0] PS_DIV64  = 8'h3F;
  localparam logic [7:0] PS_DIV256 = 8'hFF;
  // capture prescale terminal counts, fifo depth and full level
  localparam logic [3:0] EDGE_DIV4  = 4'h3;
  localparam logic [3:0] EDGE_DIV16 = 4'hF;
  localparam int FIFO_DEPTH = 4;
  localparam logic [2:0] FIFO_FULL = 3'h4;

  typedef enum logic [2:0] {
    CAP_OFF, CAP_ANY, CAP_FALL, CAP_RISE, CAP_RISE4, CAP_RISE16,
    CAP_DIS, CAP_WAKE
  } tpc_cap_mode_type;

  // bus request carried as one struct
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } tpc_bus_type;

  // device power state
  typedef struct packed {
    logic idle;
    logic sleep;
  } tpc_power_type;
endpackage : tpc_pkg

// >>> verilog/tpc_fifo_mem.sv
// four-word capture store, read data registered
module tpc_fifo_mem (
  // clock and enable
  input  wire logic        core_clk_in,
  input  wire logic        ce_in,
  // write side
  input  wire logic        wr_in,
  input  wire logic [1:0]  waddr_in,
  input  wire logic [15:0] wdata_in,
  // read side
  input  wire logic [1:0]  raddr_in,
  output logic      [15:0] rdata_out
);
  import tpc_pkg::*;
  logic [15:0] mem [FIFO_DEPTH]; // storage, no reset needed

  // write port
  always_ff @(posedge core_clk_in) begin
    if (ce_in && wr_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  // read port registered every enabled cycle
  always_ff @(posedge core_clk_in) begin
    if (ce_in) begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule : tpc_fifo_mem

// >>> verilog/tpc_timer_capture.sv
module tpc_timer_capture (
  // clock, reset, enable
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   ce_in,
  // register port
  input  wire tpc_pkg::tpc_bus_type   bus_in,
  output logic      [15:0]            rdata_out,
  // device power state
  input  wire tpc_pkg::tpc_power_type power_in,
  // external pins
  input  wire logic                   even_ext_clk_in,
  input  wire logic                   odd_ext_clk_in,
  input  wire logic                   even_gate_in,
  input  wire logic                   odd_gate_in,
  input  wire logic                   capture_pin_in,
  // event outputs
  output logic                        even_match_irq_out,
  output logic                        odd_match_irq_out,
  output logic                        capture_irq_out,
  output logic                        wake_out
);
  import tpc_pkg::*;

  // prescale terminal for a two-bit code, used twice
  function automatic logic [7:0] ps_term(input logic [1:0] code);
    case (code)
      2'b11:   ps_term = PS_DIV256;
      2'b10:   ps_term = PS_DIV64;
      2'b01:   ps_term = PS_DIV8;
      default: ps_term = PS_DIV1;
    endcase
  endfunction : ps_term

  logic [15:0] even_ctrl;       // even timer control
  logic [15:0] odd_ctrl;        // odd timer control
  logic [15:0] even_cnt;        // low timer count
  logic [15:0] odd_cnt;         // high timer count
  logic [15:0] even_per;        // even period
  logic [15:0] odd_per;         // odd period
  logic [15:0] cap_ctrl;        // capture writable bits
  logic [1:0]  ext_prev;        // previous pin levels for edges
  logic [7:0]  ps_cnt [2];      // prescale counters
  logic [1:0]  tick;            // prescaled count enable per timer
  logic        joined;          // pair operates as 32 bits
  logic        pin_prev;        // previous capture pin level
  logic [3:0]  edge_cnt;        // prescaled edge counter
  logic [1:0]  int_cnt;         // captures since last interrupt
  logic [2:0]  fill;            // buffered entries
  logic [1:0]  wptr;            // fifo write pointer
  logic [1:0]  rptr;            // fifo read pointer
  logic        ovf;             // overflow flag
  logic        cap_event;       // qualifying capture event
  logic        cap_run;         // channel active
  logic        pop;             // buffer read
  logic        rd_buf_q;        // last read was buffer
  logic [15:0] rd_reg_q;        // registered non-buffer read data
  logic [15:0] fifo_q;          // fifo read data
  logic [15:0] cap_value;       // value to store
  logic        rise;            // capture pin rising
  logic        fall;            // capture pin falling
  tpc_cap_mode_type mode;       // decoded mode

  assign joined = even_ctrl[TC_JOIN];
  assign mode   = tpc_cap_mode_type'(cap_ctrl[CC_MDHI:0]);
  assign rise   = capture_pin_in & ~pin_prev;
  assign fall   = ~capture_pin_in & pin_prev;
  assign pop    = bus_in.rd && bus_in.addr == ADDR_CAP_BUF && fill != 3'h0;

  // timer count enables; in joined mode both take even controls
  logic [15:0] cfg [2];
  logic [1:0]  ext_pin;
  logic [1:0]  gate_pin;
  assign cfg[0]      = even_ctrl;
  assign cfg[1]      = joined ? even_ctrl : odd_ctrl;
  assign ext_pin     = {joined ? even_ext_clk_in : odd_ext_clk_in,
                        even_ext_clk_in};
  assign gate_pin    = {joined ? even_gate_in : odd_gate_in, even_gate_in};

  // one prescaler and qualifier per timer
  for (genvar t = 0; t < 2; t++) begin : g_pre
    logic src_act;  // raw input tick before prescaling
    logic halted;   // idle stop active
    always_comb begin
      halted = power_in.idle && cfg[t][TC_IDLE];
      if (cfg[t][TC_CSRC]) begin
        src_act = ext_pin[t] & ~ext_prev[t];
      end else begin
        // gate only honoured with internal clock
        src_act = !cfg[t][TC_GATE] || gate_pin[t];
      end
      // sleep stops the instruction clock domain entirely
      tick[t] = cfg[t][TC_RUN] && !halted && !power_in.sleep
                && src_act && ps_cnt[t] == ps_term(cfg[t][TC_PSHI:TC_PSLO]);
    end
    // prescaler counter advances on each raw tick
    always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
        ps_cnt[t] <= 8'h00;
      end else if (ce_in) begin
        if (!cfg[t][TC_RUN]) begin
          ps_cnt[t] <= 8'h00;
        end else if (src_act && !halted && !power_in.sleep) begin
          if (ps_cnt[t] >= ps_term(cfg[t][TC_PSHI:TC_PSLO])) begin
            ps_cnt[t] <= 8'h00;
          end else begin
            ps_cnt[t] <= ps_cnt[t] + 8'h01;
          end
        end
      end
    end
  end

  // pin history for edge detection
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_prev <= 2'b00;
      pin_prev <= 1'b0;
    end else if (ce_in) begin
      ext_prev <= ext_pin;
      pin_prev <= capture_pin_in;
    end
  end

  // counters, register writes and period match
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      even_ctrl          <= 16'h0000;
      odd_ctrl           <= 16'h0000;
      even_cnt           <= 16'h0000;
      odd_cnt            <= 16'h0000;
      even_per           <= 16'hFFFF;
      odd_per            <= 16'hFFFF;
      even_match_irq_out <= 1'b0;
      odd_match_irq_out  <= 1'b0;
    end else if (ce_in) begin
      even_match_irq_out <= 1'b0;
      odd_match_irq_out  <= 1'b0;
      if (joined) begin
        // even is low word, odd is high word
        if (tick[0]) begin
          if ({odd_cnt, even_cnt} == {odd_per, even_per}) begin
            even_cnt          <= 16'h0000;
            odd_cnt           <= 16'h0000;
            odd_match_irq_out <= 1'b1;
          end else begin
            {odd_cnt, even_cnt} <= {odd_cnt, even_cnt} + 32'h0000_0001;
          end
        end
      end else begin
        if (tick[0]) begin
          if (even_cnt == even_per) begin
            even_cnt           <= 16'h0000;
            even_match_irq_out <= 1'b1;
          end else begin
            even_cnt <= even_cnt + 16'h0001;
          end
        end
        if (tick[1]) begin
          if (odd_cnt == odd_per) begin
            odd_cnt           <= 16'h0000;
            odd_match_irq_out <= 1'b1;
          end else begin
            odd_cnt <= odd_cnt + 16'h0001;
          end
        end
      end
      // software writes override the count update
      if (bus_in.wr) begin
        case (bus_in.addr)
          ADDR_EVEN_CTRL: even_ctrl <= bus_in.wdata & EVEN_CTRL_MASK;
          ADDR_ODD_CTRL:  odd_ctrl  <= bus_in.wdata & ODD_CTRL_MASK;
          ADDR_EVEN_CNT:  even_cnt  <= bus_in.wdata;
          ADDR_ODD_CNT:   odd_cnt   <= bus_in.wdata;
          ADDR_EVEN_PER:  even_per  <= bus_in.wdata;
          ADDR_ODD_PER:   odd_per   <= bus_in.wdata;
          default: ;
        endcase
      end
    end
  end

  // capture qualification
  always_comb begin
    cap_run   = !(power_in.idle && cap_ctrl[CC_IDLE]) && !power_in.sleep;
    cap_value = cap_ctrl[CC_TMR] ? even_cnt : odd_cnt;
    case (mode)
      CAP_ANY:    cap_event = cap_run && (rise || fall);
      CAP_FALL:   cap_event = cap_run && fall;
      CAP_RISE:   cap_event = cap_run && rise;
      CAP_RISE4:  cap_event = cap_run && rise && edge_cnt[1:0] == EDGE_DIV4[1:0];
      CAP_RISE16: cap_event = cap_run && rise && edge_cnt == EDGE_DIV16;
      default:    cap_event = 1'b0;
    endcase
  end

  // capture buffer storage
  tpc_fifo_mem u_fifo (
    .core_clk_in (core_clk_in),
    .ce_in       (ce_in),
    .wr_in       (cap_event && fill != FIFO_FULL),
    .waddr_in    (wptr),
    .wdata_in    (cap_value),
    .raddr_in    (rptr),
    .rdata_out   (fifo_q)
  );

  // capture channel state, pointers, flags and interrupt
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cap_ctrl        <= 16'h0000;
      edge_cnt        <= 4'h0;
      int_cnt         <= 2'b00;
      fill            <= 3'h0;
      wptr            <= 2'b00;
      rptr            <= 2'b00;
      ovf             <= 1'b0;
      capture_irq_out <= 1'b0;
      wake_out        <= 1'b0;
    end else if (ce_in) begin
      capture_irq_out <= 1'b0;
      wake_out        <= 1'b0;
      // wake interrupt on rising edge only while asleep or idle
      if (mode == CAP_WAKE && rise && (power_in.sleep || power_in.idle)) begin
        capture_irq_out <= 1'b1;
        wake_out        <= 1'b1;
      end else if (mode != CAP_WAKE && cap_event
                   && (power_in.sleep || power_in.idle)) begin
        wake_out <= 1'b1;
      end
      if (cap_run && rise && (mode == CAP_RISE4 || mode == CAP_RISE16)) begin
        edge_cnt <= edge_cnt + 4'h1;
      end
      if (cap_event) begin
        if (mode == CAP_ANY) begin
          capture_irq_out <= 1'b1;
        end else if (int_cnt == cap_ctrl[CC_CPHI:CC_CPLO]) begin
          capture_irq_out <= 1'b1;
          int_cnt         <= 2'b00;
        end else begin
          int_cnt <= int_cnt + 2'b01;
        end
      end
      // push, pop and overflow; set wins over clearing read
      if (cap_event && fill == FIFO_FULL) begin
        ovf <= 1'b1;
      end else if (pop) begin
        ovf <= 1'b0;
      end
      if (cap_event && fill != FIFO_FULL) begin
        wptr <= wptr + 2'b01;
      end
      if (pop) begin
        rptr <= rptr + 2'b01;
      end
      fill <= fill + {2'b00, cap_event && fill != FIFO_FULL}
                   - {2'b00, pop};
      if (bus_in.wr && bus_in.addr == ADDR_CAP_CTRL) begin
        cap_ctrl <= bus_in.wdata & CAP_CTRL_MASK;
        edge_cnt <= 4'h0;
        int_cnt  <= 2'b00;
        if (bus_in.wdata[CC_MDHI:0] == 3'h0) begin
          // turning the module off empties it
          fill <= 3'h0;
          wptr <= 2'b00;
          rptr <= 2'b00;
          ovf  <= 1'b0;
        end
      end
    end
  end

  // read data, registered one cycle after the strobe
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_reg_q <= 16'h0000;
      rd_buf_q <= 1'b0;
    end else if (ce_in) begin
      rd_buf_q <= bus_in.rd && bus_in.addr == ADDR_CAP_BUF;
      rd_reg_q <= 16'h0000;
      if (bus_in.rd) begin
        case (bus_in.addr)
          ADDR_EVEN_CTRL: rd_reg_q <= even_ctrl;
          ADDR_ODD_CTRL:  rd_reg_q <= odd_ctrl;
          ADDR_EVEN_CNT:  rd_reg_q <= even_cnt;
          ADDR_ODD_CNT:   rd_reg_q <= odd_cnt;
          ADDR_EVEN_PER:  rd_reg_q <= even_per;
          ADDR_ODD_PER:   rd_reg_q <= odd_per;
          ADDR_CAP_CTRL:  rd_reg_q <= cap_ctrl
                            | {11'h000, ovf, fill != 3'h0, 3'h0};
          ADDR_STATUS:    rd_reg_q <= {13'h0000, fill};
          default:        rd_reg_q <= 16'h0000;
        endcase
      end
    end
  end

  // fifo data comes from its own register, others from rd_reg_q
  assign rdata_out = rd_buf_q ? fifo_q : rd_reg_q;
endmodule : tpc_timer_capture

// >>> tb/tpc_timer_capture_monitor.sv
module tpc_timer_capture_monitor (
  // clock and reset
  input wire logic                   core_clk_in,
  input wire logic                   rst_in,
  input wire logic                   ce_in,
  // register port
  input wire tpc_pkg::tpc_bus_type   bus_in,
  input wire logic [15:0]            rdata_out,
  // power and capture pin
  input wire tpc_pkg::tpc_power_type power_in,
  input wire logic                   capture_pin_in,
  // events
  input wire logic                   even_match_irq_out,
  input wire logic                   odd_match_irq_out,
  input wire logic                   capture_irq_out,
  input wire logic                   wake_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import tpc_pkg::*;
  logic [15:0] ev;  // even control shadow
  logic [15:0] od;  // odd control shadow
  logic [15:0] cc;  // capture control shadow
  logic [1:0]  qt;  // cycles since any write, saturating
  logic [1:0]  aw;  // cycles fully awake, saturating
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // shadows track writes; the settle counters cover pulses still in flight
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ev <= 16'h0000;
      od <= 16'h0000;
      cc <= 16'h0000;
      qt <= 2'h0;
      aw <= 2'h0;
    end else if (ce_in) begin
      if (bus_in.wr && bus_in.addr == ADDR_EVEN_CTRL) ev <= bus_in.wdata;
      if (bus_in.wr && bus_in.addr == ADDR_ODD_CTRL) od <= bus_in.wdata;
      if (bus_in.wr && bus_in.addr == ADDR_CAP_CTRL) cc <= bus_in.wdata;
      qt <= bus_in.wr ? 2'h0 : (qt == 2'h3 ? qt : qt + 2'h1);
      aw <= (power_in.idle || power_in.sleep) ? 2'h0 :
            (aw == 2'h3 ? aw : aw + 2'h1);
    end
  end
  property p_even_mask;
    bus_in.rd && ce_in && bus_in.addr == ADDR_EVEN_CTRL
      |=> (rdata_out & ~EVEN_CTRL_MASK) == 16'h0000;
  endproperty
  a_even_mask : assert property (p_even_mask)
    else $error("even control reads reserved bits");
  property p_odd_mask;
    bus_in.rd && ce_in && bus_in.addr == ADDR_ODD_CTRL
      |=> (rdata_out & ~ODD_CTRL_MASK) == 16'h0000;
  endproperty
  a_odd_mask : assert property (p_odd_mask)
    else $error("odd control reads reserved bits");
  property p_cap_mask;
    bus_in.rd && ce_in && bus_in.addr == ADDR_CAP_CTRL
      |=> (rdata_out & ~(CAP_CTRL_MASK | 16'h0018)) == 16'h0000;
  endproperty
  a_cap_mask : assert property (p_cap_mask)
    else $error("capture control reads reserved bits");
  property p_run_even;
    qt == 2'h3 && !ev[TC_RUN] |-> !even_match_irq_out;
  endproperty
  a_run_even : assert property (p_run_even)
    else $error("even match while stopped");
  // when joined the even run bit governs the odd flag
  property p_run_odd;
    qt == 2'h3 && (ev[TC_JOIN] ? !ev[TC_RUN] : !od[TC_RUN])
      |-> !odd_match_irq_out;
  endproperty
  a_run_odd : assert property (p_run_odd)
    else $error("odd match while stopped");
  property p_join;
    qt == 2'h3 && ev[TC_JOIN] |-> !even_match_irq_out;
  endproperty
  a_join : assert property (p_join)
    else $error("even match flag while joined");
  property p_off;
    qt == 2'h3 && cc[2:0] == 3'h0 |-> !capture_irq_out && !wake_out;
  endproperty
  a_off : assert property (p_off)
    else $error("capture activity with module off");
  property p_wake;
    $rose(capture_pin_in) && qt == 2'h3 && cc[2:0] == 3'h7 && power_in.sleep
      |-> ##[1:4] wake_out;
  endproperty
  a_wake : assert property (p_wake)
    else $error("no wake on pin edge in sleep");
  property p_wake_irq;
    $rose(capture_pin_in) && qt == 2'h3 && cc[2:0] == 3'h7 && power_in.sleep
      |-> ##[1:4] capture_irq_out;
  endproperty
  a_wake_irq : assert property (p_wake_irq)
    else $error("no interrupt on pin edge in sleep");
  property p_awake_quiet;
    qt == 2'h3 && aw == 2'h3 && cc[2:0] == 3'h7 |-> !capture_irq_out;
  endproperty
  a_awake_quiet : assert property (p_awake_quiet)
    else $error("interrupt-only mode fired while awake");
endmodule : tpc_timer_capture_monitor

bind tpc_timer_capture tpc_timer_capture_monitor tpc_timer_capture_monitor_inst (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .bus_in(bus_in), .rdata_out(rdata_out), .power_in(power_in),
  .capture_pin_in(capture_pin_in), .even_match_irq_out(even_match_irq_out),
  .odd_match_irq_out(odd_match_irq_out), .capture_irq_out(capture_irq_out),
  .wake_out(wake_out));

// >>> tb/tpc_pin_model.sv
// drives the capture pin and the even timer clock pin; both rest low
module tpc_pin_model (
  // clock
  input  wire logic core_clk_in,
  // driven pins
  output logic      pin_out,
  output logic      ext_clk_out
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 3;  // wide levels so the input sync sees each one
  logic lvl = 1'b0;         // shared pulse level
  logic sel = 1'b0;         // high steers pulses to the clock pin
  assign pin_out     = !sel && lvl;
  assign ext_clk_out = sel && lvl;
  // n whole pulses; the target only changes while the level is low
  task automatic burst(input bit to_clk, input int n);
    sel <= to_clk;
    for (int i = 0; i < n; i++) begin
      repeat (HALF) @(posedge core_clk_in);
      lvl <= 1'b1;
      repeat (HALF) @(posedge core_clk_in);
      lvl <= 1'b0;
    end
    repeat (HALF) @(posedge core_clk_in);
  endtask : burst
endmodule : tpc_pin_model

// >>> tb/test_tpc_timer_capture.sv
module test_tpc_timer_capture;
  timeunit 1ns;
  timeprecision 1ns;
  import tpc_pkg::*;
  logic          core_clk_in, rst_in, egate, pin, eclk;
  logic          ev_irq, od_irq, cap_irq;
  tpc_bus_type   bus;
  tpc_power_type pwr;
  logic [15:0]   rdata, d, q[$];
  int            n_errors, checks, ncap;
  int            np[7] = '{4, 2, 4, 4, 8, 16, 4};  // pulses per mode
  int            nx[7] = '{0, 4, 4, 4, 2, 1, 0};   // captures per mode
  always #25 core_clk_in = ~core_clk_in;
  // capture interrupt pulses are tallied, scenarios clear the tally
  always @(posedge core_clk_in) if (cap_irq === 1'b1) ncap <= ncap + 1;
  tpc_timer_capture tpc_timer_capture_inst (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1), .bus_in(bus),
    .rdata_out(rdata), .power_in(pwr), .even_ext_clk_in(eclk),
    .odd_ext_clk_in(1'b0), .even_gate_in(egate), .odd_gate_in(1'b0),
    .capture_pin_in(pin), .even_match_irq_out(ev_irq),
    .odd_match_irq_out(od_irq), .capture_irq_out(cap_irq), .wake_out());
  tpc_pin_model tpc_pin_model_inst (
    .core_clk_in(core_clk_in), .pin_out(pin), .ext_clk_out(eclk));
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge core_clk_in);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_in);
    bus.wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk_in);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_in);
    bus.rd <= 1'b0;
    @(negedge core_clk_in);
    chk($sformatf("reg %h", a), e, rdata);
  endtask : rdc
  // spacing between two match pulses, bounded so a silent timer fails
  task automatic gap(input bit odd, input logic [15:0] e);
    int n;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(negedge core_clk_in);
        n++;
      end while (((odd ? od_irq : ev_irq) !== 1'b1) && n < 3000);
    end
    chk("match gap", e, 16'(n));
  endtask : gap
  task automatic give_verdict;
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge core_clk_in);
    n_errors++;
    give_verdict;
  end
  initial begin
    core_clk_in = 1'b0;
    rst_in = 1'b1;
    bus = '0;
    pwr = '0;
    egate = 1'b0;
    void'($urandom(32'hA711));
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rdc(ADDR_EVEN_CTRL, 16'h0000);
    rdc(ADDR_ODD_PER, 16'hFFFF);
    rdc(ADDR_CAP_CTRL, 16'h0000);
    rdc(4'hC, 16'h0000);
    repeat (3) begin
      d = 16'($urandom);
      wr(ADDR_EVEN_CTRL, d);
      rdc(ADDR_EVEN_CTRL, d & EVEN_CTRL_MASK);
      wr(ADDR_ODD_CTRL, d);
      rdc(ADDR_ODD_CTRL, d & ODD_CTRL_MASK);
      wr(ADDR_CAP_CTRL, d);
      rdc(ADDR_CAP_CTRL, d & CAP_CTRL_MASK);
    end
    wr(ADDR_ODD_CTRL, 16'h0000);
    wr(ADDR_CAP_CTRL, 16'h0000);
    // period 3 gives four ticks between matches at every division
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_EVEN_CTRL, 16'h0000);
      wr(ADDR_EVEN_CNT, 16'h0000);
      wr(ADDR_EVEN_PER, 16'h0003);
      wr(ADDR_EVEN_CTRL, 16'h8000 | 16'(p << 4));
      gap(1'b0, 16'(p == 3 ? 1024 : 4 << (3 * p)));
    end
    wr(ADDR_ODD_PER, 16'h0001);
    wr(ADDR_ODD_CTRL, 16'h8000);
    gap(1'b1, 16'h0002);
    // joined: odd word takes the carry although its own bits say stop
    wr(ADDR_EVEN_CTRL, 16'h0000);
    wr(ADDR_ODD_CTRL, 16'h0030);
    wr(ADDR_EVEN_PER, 16'hFFFF);
    wr(ADDR_ODD_PER, 16'hFFFF);
    wr(ADDR_EVEN_CNT, 16'hFFFE);
    wr(ADDR_ODD_CNT, 16'h0000);
    wr(ADDR_EVEN_CTRL, 16'h8008);
    repeat (4) @(posedge core_clk_in);
    wr(ADDR_EVEN_CTRL, 16'h0008);
    rdc(ADDR_ODD_CNT, 16'h0001);
    wr(ADDR_EVEN_CNT, 16'h0000);
    wr(ADDR_ODD_CNT, 16'h0000);
    wr(ADDR_EVEN_PER, 16'h0003);
    wr(ADDR_ODD_PER, 16'h0000);
    pwr <= '{idle: 1'b1, sleep: 1'b0};
    wr(ADDR_EVEN_CTRL, 16'h8008);
    gap(1'b1, 16'h0004);
    wr(ADDR_EVEN_CTRL, 16'h0000);
    wr(ADDR_EVEN_CNT, 16'h0000);
    wr(ADDR_EVEN_CTRL, 16'hA000);
    repeat (10) @(posedge core_clk_in);
    rdc(ADDR_EVEN_CNT, 16'h0000);
    pwr <= '0;
    // pin clock counts edges ignoring the gate bit; a low gate holds the internal clock count
    wr(ADDR_EVEN_CTRL, 16'h0000);
    wr(ADDR_EVEN_PER, 16'hFFFF);
    wr(ADDR_EVEN_CNT, 16'h0000);
    wr(ADDR_EVEN_CTRL, 16'h8042);
    tpc_pin_model_inst.burst(1'b1, 5);
    rdc(ADDR_EVEN_CNT, 16'h0005);
    wr(ADDR_EVEN_CTRL, 16'h0000);
    wr(ADDR_EVEN_CNT, 16'h0000);
    wr(ADDR_EVEN_CTRL, 16'h8040);
    repeat (10) @(posedge core_clk_in);
    rdc(ADDR_EVEN_CNT, 16'h0000);
    wr(ADDR_EVEN_CTRL, 16'h0000);
    // five captures of a stopped low timer: four kept, one overflows
    wr(ADDR_CAP_CTRL, 16'h00E3);
    ncap = 0;
    for (int i = 0; i < 5; i++) begin
      d = 16'($urandom);
      wr(ADDR_EVEN_CNT, d);
      if (i < 4) q.push_back(d);
      tpc_pin_model_inst.burst(1'b0, 1);
    end
    chk("capture irqs", 16'h0001, 16'(ncap));
    rdc(ADDR_CAP_CTRL, 16'h00FB);
    repeat (4) rdc(ADDR_CAP_BUF, q.pop_front());
    rdc(ADDR_CAP_CTRL, 16'h00E3);
    wr(ADDR_ODD_CNT, 16'h5A3C);
    wr(ADDR_CAP_CTRL, 16'h0003);
    tpc_pin_model_inst.burst(1'b0, 1);
    rdc(ADDR_CAP_BUF, 16'h5A3C);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CAP_CTRL, 16'h0000);
      wr(ADDR_CAP_CTRL, 16'h0003 | 16'(i << 5));
      ncap = 0;
      tpc_pin_model_inst.burst(1'b0, 4);
      chk("capture irqs", 16'(4 / (i + 1)), 16'(ncap));
    end
    // modes 0 to 6; every-edge mode carries a count field it must ignore
    for (int m = 0; m < 7; m++) begin
      wr(ADDR_CAP_CTRL, 16'h0000);
      wr(ADDR_CAP_CTRL, 16'(m) | (m == 1 ? 16'h0060 : 16'h0000));
      ncap = 0;
      tpc_pin_model_inst.burst(1'b0, np[m]);
      rdc(ADDR_STATUS, 16'(nx[m]));
      chk("capture irqs", 16'(nx[m]), 16'(ncap));
    end
    wr(ADDR_CAP_CTRL, 16'h0000);
    wr(ADDR_CAP_CTRL, 16'h2003);
    pwr <= '{idle: 1'b1, sleep: 1'b0};
    tpc_pin_model_inst.burst(1'b0, 2);
    rdc(ADDR_STATUS, 16'h0000);
    pwr <= '0;
    tpc_pin_model_inst.burst(1'b0, 2);
    rdc(ADDR_STATUS, 16'h0002);
    wr(ADDR_CAP_CTRL, 16'h0000);
    wr(ADDR_CAP_CTRL, 16'h0007);
    pwr <= '{idle: 1'b0, sleep: 1'b1};
    ncap = 0;
    tpc_pin_model_inst.burst(1'b0, 1);
    chk("capture irqs", 16'h0001, 16'(ncap));
    pwr <= '0;
    tpc_pin_model_inst.burst(1'b0, 1);
    chk("capture irqs", 16'h0001, 16'(ncap));
    give_verdict;
  end
endmodule : test_tpc_timer_capture
